// ---- design/eeprom_ctl.sv ----
// eeprom erase, latch, configuration shadow and timebase divisor control
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
module eeprom_ctl #(
  parameter logic [7:0] DIVH_DEFAULT = 8'h80,  // divisor_high_default contents
  parameter logic [7:0] DIVL_DEFAULT = 8'hac,  // divisor_low_default contents
  parameter int         BYTE_TICKS   = 100,    // byte erase/program length, ticks
  parameter int         BLOCK_TICKS  = 200,    // block erase length, ticks
  parameter int         BULK_TICKS   = 300     // bulk erase length, ticks
) (
  input  wire logic        mclk,             // bus clock, 20 MHz
  input  wire logic        rst_b,            // async reset, active low
  input  wire logic        ce,               // clock enable, freezes all state
  input  wire logic        hsel,             // ahb slave select
  input  wire logic [15:0] haddr,            // ahb address
  input  wire logic [1:0]  htrans,           // ahb transfer type
  input  wire logic        hwrite,           // ahb write
  input  wire logic [2:0]  hsize,            // ahb size (word only)
  input  wire logic        hready,           // ahb bus ready
  input  wire logic [31:0] hwdata,           // ahb write data
  output logic      [31:0] hrdata,           // ahb read data
  output logic             hreadyout,        // ahb slave ready
  output logic             hresp,            // ahb response, always okay
  input  wire logic        waitMode,         // cpu in wait mode
  input  wire logic        stopMode,         // cpu in stop mode
  input  wire logic        securityOptionMask, // mask option: security usable
  input  wire logic        dividerClockSelect, // mask option: 1 bus clock, 0 crystal
  input  wire logic        crystalRefClock,  // crystal reference, async pin
  output logic             chargePumpOn,     // high voltage applied to array
  output logic             arrayBusy         // access blocked after stop restart
);

  eeprom_ctl_pkg::ctrl_t  ctrl;
  eeprom_ctl_pkg::latch_t latched;
  logic [7:0]  mem [512];
  logic [7:0]  nvCfg;
  logic [7:0]  shadow;
  logic        shadowLoad;
  logic        latchValid;
  logic        dividerLockDisable;
  logic [10:0] timebaseDivisor;
  logic [10:0] divCount;
  logic        tick;
  logic [1:0]  xtalSync;
  logic        xtalPrev;
  logic [15:0] opCount;
  logic        opDone;
  logic        opFailed;
  logic        restartPending;
  logic        stopPrev;
  logic        dphWrite;
  logic        dphRead;
  logic        rdPending;
  logic [15:0] dphAddr;

  // address phase decode
  logic        addrPhase;
  logic        isArray;
  logic [8:0]  addrIndex;
  logic        isNvAddr;
  logic        validTarget;

  assign addrPhase   = hsel && hready && (htrans == eeprom_ctl_pkg::HTRANS_NONSEQ ||
                                          htrans == eeprom_ctl_pkg::HTRANS_SEQ);
  assign isArray     = haddr >= eeprom_ctl_pkg::ARRAY_BASE &&
                       haddr <= eeprom_ctl_pkg::ARRAY_END && haddr[1:0] == 2'h0;
  assign addrIndex   = haddr[10:2];
  assign isNvAddr    = haddr == eeprom_ctl_pkg::NVCFG_ADDR;
  assign validTarget = isArray || isNvAddr;

  function automatic logic secured(input logic [7:0] sh, input logic mask);
    secured = mask && !sh[eeprom_ctl_pkg::SEC_PROT_N_BIT];
  endfunction : secured

  // true when index i may be altered by the running operation
  function automatic logic mayAlter(input logic [8:0] i, input logic [7:0] sh,
                                    input logic sec);
    mayAlter = !sh[i[8:7]] &&
               !(sec && i >= eeprom_ctl_pkg::SECURE_LO && i <= eeprom_ctl_pkg::SECURE_HI);
  endfunction : mayAlter

  function automatic logic [15:0] opLength(input logic [1:0] mode);
    unique case (mode)
      eeprom_ctl_pkg::MODE_BLOCK_ERASE: opLength = 16'(BLOCK_TICKS);
      eeprom_ctl_pkg::MODE_BULK_ERASE:  opLength = 16'(BULK_TICKS);
      default:                          opLength = 16'(BYTE_TICKS);
    endcase
  endfunction : opLength

  logic secureNow;
  logic accessBlocked;
  logic opRunning;
  logic opFinish;
  logic ctrlWrite;
  logic divWriteOk;

  assign secureNow     = secured(shadow, securityOptionMask);
  assign accessBlocked = restartPending || ctrl.arrayPowerDown;
  assign opRunning     = ctrl.highVoltageEnable && !opDone && !stopMode;
  assign opFinish      = opRunning && tick && opCount + 16'h0001 >= opLength(ctrl.eraseModeSel);
  assign ctrlWrite     = dphWrite && dphAddr == eeprom_ctl_pkg::CTRL_ADDR &&
                         (!ctrl.busLatchEnable || latchValid);
  assign divWriteOk    = !ctrl.busLatchEnable && dividerLockDisable;
  assign chargePumpOn  = ctrl.highVoltageEnable && !stopMode && !opDone;
  assign arrayBusy     = restartPending;
  assign hresp         = 1'b0;
  assign hreadyout     = !rdPending;

  // ahb phase tracking; reads take one wait state so hrdata sees settled state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dphWrite  <= 1'b0;
      dphRead   <= 1'b0;
      rdPending <= 1'b0;
      dphAddr   <= 16'h0000;
    end else if (ce) begin
      if (hreadyout) begin
        dphWrite  <= addrPhase && hwrite;
        dphRead   <= addrPhase && !hwrite;
        rdPending <= addrPhase && !hwrite;
        dphAddr   <= haddr;
      end else begin
        rdPending <= 1'b0;
        dphRead   <= 1'b0;
      end
    end
  end

  // read data mux, captured in the wait cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (ce && rdPending) begin
      if (dphAddr >= eeprom_ctl_pkg::ARRAY_BASE && dphAddr <= eeprom_ctl_pkg::ARRAY_END) begin
        if (accessBlocked)
          hrdata <= {24'h000000, eeprom_ctl_pkg::ERASED_BYTE};
        else if (ctrl.busLatchEnable)
          hrdata <= {24'h000000, latched.data};
        else
          hrdata <= {24'h000000, mem[dphAddr[10:2]]};
      end else begin
        unique case (dphAddr)
          eeprom_ctl_pkg::CTRL_ADDR:     hrdata <= {24'h000000, ctrl};
          eeprom_ctl_pkg::SHADOW_ADDR:   hrdata <= {24'h000000, shadow};
          eeprom_ctl_pkg::DIVH_ADDR:
            hrdata <= {24'h000000, dividerLockDisable, 4'h0, timebaseDivisor[10:8]};
          eeprom_ctl_pkg::DIVL_ADDR:     hrdata <= {24'h000000, timebaseDivisor[7:0]};
          eeprom_ctl_pkg::DIVH_DEF_ADDR: hrdata <= {24'h000000, DIVH_DEFAULT};
          eeprom_ctl_pkg::DIVL_DEF_ADDR: hrdata <= {24'h000000, DIVL_DEFAULT};
          eeprom_ctl_pkg::NVCFG_ADDR:
            hrdata <= {24'h000000, ctrl.busLatchEnable ? latched.data : nvCfg};
          default:                       hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // array control register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= eeprom_ctl_pkg::CTRL_RESET;
    end else if (ce) begin
      // a stop entered without both latch and hv set drops hv; a same-cycle write is lost
      if (stopMode && !stopPrev && !(ctrl.busLatchEnable && ctrl.highVoltageEnable)) begin
        ctrl.highVoltageEnable <= 1'b0;
      end else if (ctrlWrite) begin
        ctrl.spareBit       <= hwdata[7];
        ctrl.arrayPowerDown <= hwdata[6];
        ctrl.autoTerminate  <= hwdata[1];
        if (!ctrl.highVoltageEnable)
          ctrl.eraseModeSel <= hwdata[5:4];
        // clearing both only drops the voltage enable
        if (!ctrl.highVoltageEnable || !hwdata[0])
          ctrl.busLatchEnable <= hwdata[3] || ctrl.highVoltageEnable;
        // refused set leaves the bit low without complaint
        if (hwdata[0] && ctrl.busLatchEnable && latchValid)
          ctrl.highVoltageEnable <= 1'b1;
        else if (!hwdata[0])
          ctrl.highVoltageEnable <= 1'b0;
        else if (!ctrl.highVoltageEnable)
          ctrl.highVoltageEnable <= 1'b0;
        if (opFinish && ctrl.autoTerminate)
          ctrl.highVoltageEnable <= 1'b0;
      end else if (opFinish && ctrl.autoTerminate) begin
        ctrl.highVoltageEnable <= 1'b0;
      end
    end
  end

  // address and data latch
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latched    <= '0;
      latchValid <= 1'b0;
    end else if (ce) begin
      if (!ctrl.busLatchEnable) begin
        latchValid <= 1'b0;
      end else if (dphWrite && !ctrl.highVoltageEnable &&
                   (dphAddr == eeprom_ctl_pkg::NVCFG_ADDR ||
                    (dphAddr >= eeprom_ctl_pkg::ARRAY_BASE &&
                     dphAddr <= eeprom_ctl_pkg::ARRAY_END && dphAddr[1:0] == 2'h0))) begin
        latched.isNvCfg <= dphAddr == eeprom_ctl_pkg::NVCFG_ADDR;
        latched.index   <= dphAddr[10:2];
        latched.data    <= hwdata[7:0];
        latchValid      <= 1'b1;
      end else if (addrPhase && !hwrite && validTarget && !ctrl.highVoltageEnable) begin
        latched.isNvCfg <= isNvAddr;
        latched.index   <= addrIndex;
      end
    end
  end

  // erase/program timing in timebase ticks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      opCount        <= 16'h0000;
      opDone         <= 1'b0;
      opFailed       <= 1'b0;
      restartPending <= 1'b0;
      stopPrev       <= 1'b0;
    end else if (ce) begin
      // wait mode deliberately not looked at here
      stopPrev <= stopMode;
      if (!ctrl.highVoltageEnable) begin
        opCount  <= 16'h0000;
        opDone   <= 1'b0;
        opFailed <= 1'b0;
        restartPending <= 1'b0;
      end else if (stopMode) begin
        opCount <= 16'h0000;
        if (!stopPrev && ctrl.busLatchEnable && !opDone)
          restartPending <= 1'b1;
      end else begin
        // an array or configuration byte read during high voltage spoils the cycle
        if (addrPhase && !hwrite && validTarget)
          opFailed <= 1'b1;
        if (opFinish) begin
          opDone         <= 1'b1;
          restartPending <= 1'b0;
        end else if (opRunning && tick) begin
          opCount <= opCount + 16'h0001;
        end
      end
    end
  end

  // array storage and non-volatile configuration byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // blank array and factory byte on reset: a model shortcut, real cells keep charge
      nvCfg <= eeprom_ctl_pkg::NVCFG_FACTORY;
      for (int i = 0; i < 512; i++)
        mem[i] <= eeprom_ctl_pkg::ERASED_BYTE;
    end else if (ce && opFinish && !opFailed && !ctrl.arrayPowerDown) begin
      unique case (ctrl.eraseModeSel)
        eeprom_ctl_pkg::MODE_PROGRAM: begin
          if (latched.isNvCfg) begin
            if (!secureNow)
              nvCfg <= nvCfg & latched.data;
          end else if (mayAlter(latched.index, shadow, secureNow)) begin
            mem[latched.index] <= mem[latched.index] & latched.data;
          end
        end
        eeprom_ctl_pkg::MODE_BYTE_ERASE: begin
          if (latched.isNvCfg) begin
            if (!secureNow)
              nvCfg <= eeprom_ctl_pkg::ERASED_BYTE;
          end else if (mayAlter(latched.index, shadow, secureNow)) begin
            mem[latched.index] <= eeprom_ctl_pkg::ERASED_BYTE;
          end
        end
        eeprom_ctl_pkg::MODE_BLOCK_ERASE: begin
          // configuration byte untouched; a secured part refuses this mode
          for (int i = 0; i < 512; i++)
            if (!secureNow && !latched.isNvCfg && 2'(i >> 7) == latched.index[8:7] &&
                mayAlter(9'(i), shadow, 1'b0))
              mem[i] <= eeprom_ctl_pkg::ERASED_BYTE;
        end
        eeprom_ctl_pkg::MODE_BULK_ERASE: begin
          for (int i = 0; i < 512; i++)
            if (!secureNow && mayAlter(9'(i), shadow, 1'b0))
              mem[i] <= eeprom_ctl_pkg::ERASED_BYTE;
        end
      endcase
    end
  end

  // shadow copy after reset release and after a read of the configuration byte with the bus latch off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shadow     <= eeprom_ctl_pkg::NVCFG_FACTORY;
      shadowLoad <= 1'b1;
    end else if (ce) begin
      shadowLoad <= 1'b0;
      if (shadowLoad || (rdPending && dphAddr == eeprom_ctl_pkg::NVCFG_ADDR &&
                         !ctrl.busLatchEnable))
        shadow <= nvCfg;
    end
  end

  // timebase divisor registers, loaded from the hard-wired defaults
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dividerLockDisable <= DIVH_DEFAULT[eeprom_ctl_pkg::LOCK_DISABLE_BIT];
      timebaseDivisor    <= {DIVH_DEFAULT[2:0], DIVL_DEFAULT};
    end else if (ce && dphWrite && divWriteOk) begin
      if (dphAddr == eeprom_ctl_pkg::DIVH_ADDR) begin
        dividerLockDisable     <= hwdata[eeprom_ctl_pkg::LOCK_DISABLE_BIT];
        timebaseDivisor[10:8]  <= hwdata[2:0];
      end else if (dphAddr == eeprom_ctl_pkg::DIVL_ADDR) begin
        timebaseDivisor[7:0]   <= hwdata[7:0];
      end
    end
  end

  // crystal reference is asynchronous: two flops, then edge detect on the second
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xtalSync <= 2'h0;
      xtalPrev <= 1'b0;
    end else if (ce) begin
      xtalSync <= {xtalSync[0], crystalRefClock};
      xtalPrev <= xtalSync[1];
    end
  end

  // divider: one tick per divisor reference edges; crystal limited to below mclk/2
  logic refEdge;
  assign refEdge = dividerClockSelect ? 1'b1 : (xtalSync[1] && !xtalPrev);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= 11'h000;
      tick     <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (refEdge) begin
        // a divisor of zero or one ticks on every reference edge
        if (divCount + 11'h001 >= timebaseDivisor) begin
          divCount <= 11'h000;
          tick     <= 1'b1;
        end else begin
          divCount <= divCount + 11'h001;
        end
      end
    end
  end

endmodule : eeprom_ctl

// ---- design/eeprom_ctl_pkg.sv ----
// shared constants and types for the eeprom erase and configuration control
package eeprom_ctl_pkg;

  // register byte addresses on the 32-bit bus
  localparam logic [15:0] CTRL_ADDR       = 16'h0000;
  localparam logic [15:0] SHADOW_ADDR     = 16'h0004;
  localparam logic [15:0] DIVH_ADDR       = 16'h0008;
  localparam logic [15:0] DIVL_ADDR       = 16'h000c;
  localparam logic [15:0] DIVH_DEF_ADDR   = 16'h0010;
  localparam logic [15:0] DIVL_DEF_ADDR   = 16'h0014;
  localparam logic [15:0] NVCFG_ADDR      = 16'hfe1c;
  // array byte i sits at ARRAY_BASE + 4*i
  localparam logic [15:0] ARRAY_BASE      = 16'h1000;
  localparam logic [15:0] ARRAY_END       = 16'h17fc;

  // erase mode select encodings
  localparam logic [1:0] MODE_PROGRAM     = 2'h0;
  localparam logic [1:0] MODE_BYTE_ERASE  = 2'h1;
  localparam logic [1:0] MODE_BLOCK_ERASE = 2'h2;
  localparam logic [1:0] MODE_BULK_ERASE  = 2'h3;

  // field positions
  localparam int LOCK_DISABLE_BIT = 7;
  localparam int SEC_PROT_N_BIT   = 4;

  // reset values
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] NVCFG_FACTORY   = 8'h10;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;
  // secured window inside block 1, indices 0x0f0..0x0ff
  localparam logic [8:0] SECURE_LO       = 9'h0f0;
  localparam logic [8:0] SECURE_HI       = 9'h0ff;

  localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0] HTRANS_SEQ      = 2'h3;

  // array control register layout
  typedef struct packed {
    logic       spareBit;          // 7
    logic       arrayPowerDown;    // 6
    logic [1:0] eraseModeSel;      // 5:4
    logic       busLatchEnable;    // 3
    logic       reserved;          // 2
    logic       autoTerminate;     // 1
    logic       highVoltageEnable; // 0
  } ctrl_t;

  // latched target: configuration byte or array index
  typedef struct packed {
    logic       isNvCfg;
    logic [8:0] index;
    logic [7:0] data;
  } latch_t;

endpackage : eeprom_ctl_pkg

// ---- tb/ahb_master.sv ----
// ahb-lite single-word master standing in for the cpu
`timescale 1ns/1ns
module ahb_master (
  input  wire logic        mclk,   // bus clock
  output logic             hsel,   // slave select
  output logic      [15:0] haddr,  // address
  output logic      [1:0]  htrans, // transfer type
  output logic             hwrite, // write
  output logic      [31:0] hwdata, // write data
  input  wire logic        hready, // bus ready
  input  wire logic [31:0] hrdata  // read data
);
  initial begin
    hsel = 1'b0;
    haddr = 16'h0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // hready sampled mid-cycle so the edge that ends a phase sees a settled value
  task automatic wait_ready(inout int n, output logic [31:0] rd);
    logic rdy;
    do begin
      @(negedge mclk);
      rdy = hready;
      rd = hrdata;
      @(posedge mclk);
      n++;
    end while (rdy !== 1'b1 && n < 64);
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic tmo);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= eeprom_ctl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready(n, rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(n, rd);
    tmo = (n >= 64);
  endtask : xfer
endmodule : ahb_master

// ---- tb/eeprom_ctl_properties.sv ----
// concurrent checks on the control block's bus, pump and busy ports
`timescale 1ns/1ns
module eeprom_ctl_properties (
  input wire logic        mclk,         // bus clock
  input wire logic        rst_b,        // async reset, active low
  input wire logic        hsel,         // slave select
  input wire logic [15:0] haddr,        // address
  input wire logic [1:0]  htrans,       // transfer type
  input wire logic        hwrite,       // write
  input wire logic        hready,       // bus ready
  input wire logic [31:0] hrdata,       // read data
  input wire logic        hreadyout,    // slave ready
  input wire logic        hresp,        // response
  input wire logic        stopMode,     // stop mode
  input wire logic        chargePumpOn, // high voltage on
  input wire logic        arrayBusy     // busy after restart
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic rdTaken;
  logic ctrlWr;
  assign rdTaken = hsel & hready & htrans[1] & !hwrite;
  assign ctrlWr  = hsel & hready & htrans[1] & hwrite & (haddr == eeprom_ctl_pkg::CTRL_ADDR);
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (rdTaken |=> one_wait)
    else $error("read data phase is not one wait cycle");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_wait_cause: assert property (!hreadyout |-> $past(rdTaken))
    else $error("wait state without a read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_data_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_data_hold: assert property ($changed(hrdata) |-> $past(rdTaken, 2))
    else $error("read data changed without a read");
  a_stop_pump: assert property (stopMode |-> !chargePumpOn)
    else $error("high voltage on during stop");
  a_pump_cause: assert property ($rose(chargePumpOn) && !$past(stopMode) |-> $past(ctrlWr, 2))
    else $error("high voltage rose without a control write");
  a_busy_cause: assert property ($rose(arrayBusy) |-> $past(stopMode))
    else $error("busy rose without stop");
endmodule : eeprom_ctl_properties

// ---- tb/eeprom_erase_config_control_tb_top.sv ----
// bench for the eeprom control block: scenarios and verdict
`timescale 1ns/1ns
module eeprom_erase_config_control_tb_top;
  localparam logic [15:0] CTL = eeprom_ctl_pkg::CTRL_ADDR;
  localparam logic [15:0] NVC = eeprom_ctl_pkg::NVCFG_ADDR;
  localparam logic [15:0] DVH = eeprom_ctl_pkg::DIVH_ADDR;
  localparam logic [15:0] DVL = eeprom_ctl_pkg::DIVL_ADDR;
  logic        mclk, rst_b, waitMode, stopMode, hsel, hwrite, hreadyout, hresp;
  logic        chargePumpOn, arrayBusy;
  logic        ce, securityOptionMask, dividerClockSelect, crystalRefClock;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  int          nFail = 0;
  int          numChecks = 0;
  // divisor 2 and two-tick cycles keep erase runs short
  eeprom_ctl #(.DIVH_DEFAULT(8'h80), .DIVL_DEFAULT(8'h02), .BYTE_TICKS(2),
               .BLOCK_TICKS(2), .BULK_TICKS(2)) DUT (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .waitMode(waitMode), .stopMode(stopMode),
    .securityOptionMask(securityOptionMask), .dividerClockSelect(dividerClockSelect),
    .crystalRefClock(crystalRefClock),
    .chargePumpOn(chargePumpOn), .arrayBusy(arrayBusy));
  ahb_master u_cpu (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  function automatic logic [15:0] ax(input int i);
    return eeprom_ctl_pkg::ARRAY_BASE + 16'(4 * i);
  endfunction : ax
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic tmo;
    u_cpu.xfer(w, a, d, r, tmo);
    if (tmo) begin
      nFail++;
      end_of_test;
    end
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rc
  task automatic start(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    wr(CTL, {26'h0, m, 4'h8});
    wr(a, {24'h0, d});
  endtask : start
  task automatic finish(input logic [1:0] m);
    logic [31:0] r;
    int n;
    wr(CTL, {26'h0, m, 4'hb});
    n = 0;
    do begin
      bus(1'b0, CTL, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 30);
    chk({31'h0, r[0]}, 32'h0);
    if (r[0] !== 1'b0) end_of_test;
    wr(CTL, 32'h0);
  endtask : finish
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // crystal reference, four bus clocks per period, edges off the rising edge
  initial begin
    crystalRefClock = 1'b0;
    forever #100 crystalRefClock = ~crystalRefClock;
  end
  initial begin
    logic [31:0] r;
    int n;
    rst_b = 1'b0;
    waitMode = 1'b0;
    stopMode = 1'b0;
    ce = 1'b1;
    securityOptionMask = 1'b0;
    dividerClockSelect = 1'b1;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rc(CTL, 32'h0);
    rc(eeprom_ctl_pkg::SHADOW_ADDR, 32'h10);
    wr(eeprom_ctl_pkg::SHADOW_ADDR, 32'h0f);
    rc(eeprom_ctl_pkg::SHADOW_ADDR, 32'h10);
    rc(DVH, 32'h80);
    rc(DVL, 32'h02);
    rc(eeprom_ctl_pkg::DIVL_DEF_ADDR, 32'h02);
    wr(16'h0018, 32'hff);
    rc(16'h0018, 32'h0);
    // refused requests
    wr(CTL, 32'h01);
    rc(CTL, 32'h0);
    wr(CTL, 32'h18);
    wr(16'h0018, 32'h0);
    wr(CTL, 32'h19);
    rc(CTL, 32'h18);
    wr(ax(9), 32'h0);
    wr(CTL, 32'h0);
    rc(CTL, 32'h0);
    // program with a relatching read
    start(2'h0, ax(5), 8'h3c);
    rc(ax(9), 32'h3c);
    finish(2'h0);
    rc(ax(9), 32'h3c);
    rc(ax(5), 32'hff);
    // manual byte erase: frozen mode, staged clears
    start(2'h1, ax(9), 8'h00);
    wr(CTL, 32'h19);
    wr(CTL, 32'h29);
    rc(CTL, 32'h19);
    repeat (16) @(posedge mclk);
    wr(CTL, 32'h0);
    rc(CTL, 32'h18);
    wr(CTL, 32'h0);
    rc(CTL, 32'h0);
    rc(ax(9), 32'hff);
    // bulk erase across wait mode
    start(2'h0, ax(300), 8'h00);
    finish(2'h0);
    rc(ax(300), 32'h0);
    start(2'h0, ax(130), 8'h00);
    finish(2'h0);
    start(2'h2, ax(260), 8'h00);
    finish(2'h2);
    rc(ax(300), 32'hff);
    rc(ax(130), 32'h0);
    waitMode <= 1'b1;
    start(2'h3, ax(0), 8'h00);
    finish(2'h3);
    waitMode <= 1'b0;
    rc(ax(300), 32'hff);
    rc(ax(130), 32'hff);
    rc(NVC, 32'h10);
    // stop in mid-cycle
    start(2'h1, ax(20), 8'h00);
    wr(CTL, 32'h19);
    stopMode <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, chargePumpOn}, 32'h0);
    chk({31'h0, arrayBusy}, 32'h1);
    @(posedge mclk);
    stopMode <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (arrayBusy !== 1'b0 && n < 60);
    chk({31'h0, arrayBusy}, 32'h0);
    if (arrayBusy !== 1'b0) end_of_test;
    wr(CTL, 32'h0);
    wr(CTL, 32'h0);
    rc(CTL, 32'h0);
    // erased config byte protects every block
    start(2'h1, NVC, 8'h00);
    finish(2'h1);
    rc(NVC, 32'hff);
    // security bit low with the mask set locks the configuration byte
    start(2'h0, NVC, 8'hef);
    finish(2'h0);
    rc(NVC, 32'hef);
    securityOptionMask <= 1'b1;
    start(2'h1, NVC, 8'h00);
    finish(2'h1);
    rc(NVC, 32'hef);
    securityOptionMask <= 1'b0;
    start(2'h1, NVC, 8'h00);
    finish(2'h1);
    rc(NVC, 32'hff);
    bus(1'b0, eeprom_ctl_pkg::SHADOW_ADDR, 32'h0, r);
    chk(r & 32'h1f, 32'h1f);
    start(2'h0, ax(0), 8'h00);
    finish(2'h0);
    rc(ax(0), 32'hff);
    // divisor write gating and lock
    wr(DVL, 32'h03);
    rc(DVL, 32'h03);
    start(2'h1, ax(40), 8'h00);
    wr(DVL, 32'h05);
    rc(DVL, 32'h03);
    wr(CTL, 32'h0);
    wr(DVL, 32'h02);
    wr(DVH, 32'h00);
    rc(DVH, 32'h00);
    wr(DVL, 32'h07);
    rc(DVL, 32'h02);
    wr(DVH, 32'h80);
    rc(DVH, 32'h00);
    // crystal reference: frozen, then slow enough to outlast six bus-clock cycles
    dividerClockSelect <= 1'b0;
    start(2'h1, ax(60), 8'h00);
    wr(CTL, 32'h1b);
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, chargePumpOn}, 32'h1);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, chargePumpOn}, 32'h1);
    finish(2'h1);
    dividerClockSelect <= 1'b1;
    // second reset restores the divisor defaults
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rc(DVH, 32'h80);
    rc(CTL, 32'h0);
    end_of_test;
  end
endmodule : eeprom_erase_config_control_tb_top
bind eeprom_ctl eeprom_ctl_properties u_props (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .stopMode(stopMode),
  .chargePumpOn(chargePumpOn), .arrayBusy(arrayBusy));
